// File: sac_pkg.sv
// Purpose: Shared constants for the successive-approximation converter control
// Assumes: Avalon-MM slave with 32-bit data, one word per register
// Notes:   Offsets 0x1f and 0x9f are register indices; byte address is 4x
package sac_pkg;

    localparam logic [7:0] SAC_IDX_CTRL    = 8'h1f;
    localparam logic [7:0] SAC_IDX_PINCFG  = 8'h9f;
    localparam logic [7:0] SAC_IDX_RESULT  = 8'h1e;
    localparam logic [7:0] SAC_IDX_STATUS  = 8'h20;

    localparam logic [7:0] SAC_CTRL_RST    = 8'h00;
    localparam logic [2:0] SAC_PINCFG_RST  = 3'h0;

    // Control field positions
    localparam int SAC_CLKSEL_LSB = 6;
    localparam int SAC_CHSEL_LSB  = 3;
    localparam int SAC_START_BIT  = 2;
    localparam int SAC_ENABLE_BIT = 0;

    // Clock select codes
    localparam logic [1:0] SAC_CLK_DIV2  = 2'h0;
    localparam logic [1:0] SAC_CLK_DIV8  = 2'h1;
    localparam logic [1:0] SAC_CLK_DIV32 = 2'h2;
    localparam logic [1:0] SAC_CLK_RC    = 2'h3;

    // Divider ratios minus one, in core clocks
    localparam logic [4:0] SAC_DIV2_M1  = 5'h01;
    localparam logic [4:0] SAC_DIV8_M1  = 5'h07;
    localparam logic [4:0] SAC_DIV32_M1 = 5'h1f;

    // Half-periods: conversion 9.5 periods, hold-off 2.0 periods
    localparam logic [4:0] SAC_CONV_HALVES = 5'h13;
    localparam logic [4:0] SAC_HOLD_HALVES = 5'h04;
    localparam int         SAC_RES_BITS    = 8;

    // One instruction cycle before an RC-clocked start, in core clocks
    localparam real        SAC_INSTR_NS     = 400.0;
    localparam real        SAC_CLK_MHZ      = 250.0;
    localparam logic [7:0] SAC_INSTR_CYCLES =
        8'(int'(SAC_INSTR_NS * SAC_CLK_MHZ / 1000.0));

    typedef enum logic [1:0] {
        SAC_IDLE  = 2'b00,
        SAC_DELAY = 2'b01,
        SAC_CONV  = 2'b10,
        SAC_HOLD  = 2'b11
    } sac_state_t;

endpackage : sac_pkg

// File: sac_adc_ctrl.sv
// Purpose: Control and sequencing of a four-input 8-bit SAR converter
// Assumes: Comparator answers within one core clock; sleep is a level input
// Notes:   The RC conversion clock arrives as a one-cycle enable pulse
//
// Summary of operation
// [RQ1] Eight-bit result by successive approximation
// [RQ2] Bits 7-6 select osc/2, /8, /32, RC
// [RQ3] Bits 4-3 route one of four inputs
// [RQ4] Setting bit 2 while enabled starts conversion
// [RQ5] Hardware clears bit 2 when done
// [RQ6] Bit 0 enables converter, else powered off
// [RQ7] Control register read/write, resets to zero
// [RQ8] Pin config: three bits, upper read zero
// [RQ9] Config code sets analog/digital pin mapping
// [RQ10] Codes 001, 011, 101 use pin-one reference
// [RQ11] Port read of analog pin returns zero
// [RQ12] Config write may set pin-change, external flags
// [RQ13] Completion loads result, clears busy, sets flag
// [RQ14] Conversion lasts 9.5 bit periods
// [RQ15] Capacitor disconnected 2.0 periods after conversion
// [RQ16] Holding capacitor never discharged between conversions
// [RQ17] Software waits acquisition time before start
// [RQ18] Software configures, enables, acquires, starts, reads
// [RQ19] Software keeps bit period at least 1.6 us
// [RQ20] Converter may run during sleep
// [RQ21] RC waits one instruction; else sleep aborts
// [RQ22] Clearing busy aborts, result kept, 2-period wait
// [RQ23] Reset turns off, aborts, result untouched
// [RQ24] Start ignored while converter disabled
`timescale 1ns/1ps

module sac_adc_ctrl
    import sac_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Avalon-MM slave
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Analog front end
    input  wire logic        rc_tick,
    input  wire logic        sleep_mode,
    input  wire logic        comparator_high,
    output logic      [1:0]  analog_mux_sel,
    output logic             sample_switch_on,
    output logic             converter_powered,
    output logic             ref_from_pin_one,
    output logic      [7:0]  dac_code,
    // Port pins (bit 3 is pin four)
    input  wire logic [3:0]  port_pins_in,
    output logic      [3:0]  port_pins_read,
    output logic      [3:0]  pin_analog,
    // Interrupt side effects
    output logic             conversion_done_flag,
    output logic             pin_change_flag_set,
    output logic             external_irq_flag_set
);

    logic [7:0]  converter_control_q;
    logic [2:0]  port_config_code_q;
    logic [7:0]  conversion_result_q;
    logic [7:0]  sar_q;
    logic [3:0]  bit_idx_q;
    sac_state_t  state_q;
    logic [4:0]  div_cnt_q;
    logic        half_q;
    logic [4:0]  halves_q;
    logic [7:0]  dly_q;
    logic        start_pend_q;
    logic        done_q;

    logic [1:0]  clk_sel;
    logic        enabled;
    logic        busy_bit;
    logic        tick;
    logic        div_tick;
    logic [4:0]  div_m1;
    logic        run;
    logic        wr_ctrl;
    logic        wr_cfg;
    logic        rd_ok;
    logic [3:0]  analog_map;
    logic [31:0] rd_word;
    logic        sleep_abort;
    logic        sw_abort;
    logic        finish;

    assign clk_sel  = converter_control_q[SAC_CLKSEL_LSB +: 2];
    assign enabled  = converter_control_q[SAC_ENABLE_BIT];
    assign busy_bit = converter_control_q[SAC_START_BIT];
    // Writes land only at the edge that answers the master, once each
    assign wr_ctrl  = avs_write && avs_byteenable[0] && !avs_waitrequest
                      && avs_address[9:2] == SAC_IDX_CTRL;
    assign wr_cfg   = avs_write && avs_byteenable[0] && !avs_waitrequest
                      && avs_address[9:2] == SAC_IDX_PINCFG;

    // Non-RC sources abort in sleep; RC keeps running
    assign sleep_abort = sleep_mode && clk_sel != SAC_CLK_RC;   // [RQ21] [RQ20]
    assign run         = enabled && !sleep_abort;                // [RQ6]
    assign sw_abort    = wr_ctrl && !avs_writedata[SAC_START_BIT]
                         && (state_q == SAC_CONV || state_q == SAC_DELAY);

    // Clock source selection; each tick is a half conversion period
    always_comb begin
        case (clk_sel)                                           // [RQ2]
            SAC_CLK_DIV2:  div_m1 = SAC_DIV2_M1;
            SAC_CLK_DIV8:  div_m1 = SAC_DIV8_M1;
            SAC_CLK_DIV32: div_m1 = SAC_DIV32_M1;
            default:       div_m1 = SAC_DIV2_M1;
        endcase
    end
    assign div_tick = (div_cnt_q >= (div_m1 >> 1));
    assign tick     = (clk_sel == SAC_CLK_RC) ? rc_tick : div_tick;

    always_ff @(posedge clk) begin
        // Restart the divider before each conversion so that its
        // length does not depend on the phase of a free-running count
        if (!nrst || !run || div_tick
            || state_q == SAC_IDLE || state_q == SAC_DELAY)
            div_cnt_q <= 5'h00;
        else
            div_cnt_q <= div_cnt_q + 5'h01;
    end

    // Pin mapping from configuration code: {pin4, pin2, pin1, pin0}
    always_comb begin
        case (port_config_code_q)                                // [RQ9]
            3'h0, 3'h1: analog_map = 4'hf;
            3'h2, 3'h3: analog_map = 4'h7;
            3'h4, 3'h5: analog_map = 4'h3;
            3'h6:       analog_map = 4'h1;
            default:    analog_map = 4'h0;
        endcase
    end

    // Control register with hardware-owned busy bit
    always_ff @(posedge clk) begin
        if (!nrst) begin
            converter_control_q <= SAC_CTRL_RST;                 // [RQ7] [RQ23]
        end else if (wr_ctrl) begin
            converter_control_q <= avs_writedata[7:0];           // [RQ7]
            if (!enabled || !avs_writedata[SAC_ENABLE_BIT])
                converter_control_q[SAC_START_BIT] <= 1'b0;      // [RQ24]
        end else if (finish || sleep_abort) begin
            converter_control_q[SAC_START_BIT] <= 1'b0;          // [RQ5]
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst)
            port_config_code_q <= SAC_PINCFG_RST;                // [RQ8]
        else if (wr_cfg)
            port_config_code_q <= avs_writedata[2:0];
    end

    // Sequencer: delay, 19 half-periods converting, 4 half-periods hold-off
    assign finish = state_q == SAC_CONV && tick
                    && halves_q == SAC_CONV_HALVES - 5'h01;      // [RQ14]

    always_ff @(posedge clk) begin
        if (!nrst || !run) begin
            state_q      <= SAC_IDLE;                            // [RQ23] [RQ6]
            halves_q     <= 5'h00;
            dly_q        <= 8'h00;
            start_pend_q <= 1'b0;
        end else begin
            start_pend_q <= wr_ctrl && avs_writedata[SAC_START_BIT]
                            && !busy_bit && enabled;             // [RQ4] [RQ24]
            // Idle: sampling; delay: RC settle; conv: decide; hold: isolate
            case (state_q)
                SAC_IDLE: begin
                    if (start_pend_q) begin
                        state_q <= SAC_DELAY;
                        dly_q   <= (clk_sel == SAC_CLK_RC)
                                   ? SAC_INSTR_CYCLES : 8'h00;   // [RQ21]
                    end
                end
                SAC_DELAY: begin
                    if (sw_abort) begin
                        state_q  <= SAC_HOLD;
                        halves_q <= 5'h00;
                    end else if (dly_q == 8'h00) begin
                        state_q  <= SAC_CONV;
                        halves_q <= 5'h00;
                    end else
                        dly_q <= dly_q - 8'h01;
                end
                SAC_CONV: begin
                    if (sw_abort || finish) begin
                        state_q  <= SAC_HOLD;                    // [RQ22] [RQ15]
                        halves_q <= 5'h00;
                    end else if (tick)
                        halves_q <= halves_q + 5'h01;
                end
                SAC_HOLD: begin
                    if (tick && halves_q == SAC_HOLD_HALVES - 5'h01)
                        state_q <= SAC_IDLE;                     // [RQ15] [RQ22]
                    else if (tick)
                        halves_q <= halves_q + 5'h01;
                end
                default: state_q <= SAC_IDLE;
            endcase
        end
    end

    // Successive approximation: one bit decided per full period
    always_ff @(posedge clk) begin
        if (!nrst || state_q != SAC_CONV) begin
            sar_q     <= 8'h80;
            bit_idx_q <= 4'(SAC_RES_BITS - 1);
        end else if (tick && halves_q[0] && bit_idx_q != 4'hf) begin
            sar_q[bit_idx_q[2:0]] <= comparator_high;            // [RQ1]
            if (bit_idx_q != 4'h0)
                sar_q[bit_idx_q[2:0] - 3'h1] <= 1'b1;
            bit_idx_q <= bit_idx_q - 4'h1;
        end
    end

    // Result kept across reset and abort
    // No reset branch on purpose: contents survive a device reset
    always_ff @(posedge clk) begin
        if (finish && run && !sw_abort)
            conversion_result_q <= sar_q;                        // [RQ13] [RQ23]
    end

    always_ff @(posedge clk) begin
        if (!nrst)
            done_q <= 1'b0;
        else
            done_q <= finish && run && !sw_abort;                // [RQ13]
    end

    // Channel routed to the sampler
    always_ff @(posedge clk) begin
        if (!nrst)
            analog_mux_sel <= 2'h0;
        else
            analog_mux_sel <= converter_control_q[SAC_CHSEL_LSB +: 2]; // [RQ3]
    end

    // Never discharged: switch only connects or isolates
    always_ff @(posedge clk) begin
        if (!nrst)
            sample_switch_on <= 1'b0;
        else
            sample_switch_on <= run && state_q == SAC_IDLE; // [RQ16] [RQ15]
    end

    // Power follows enable, dropped by a sleep abort
    always_ff @(posedge clk) begin
        if (!nrst)
            converter_powered <= 1'b0;
        else
            converter_powered <= run;                       // [RQ6] [RQ20]
    end

    // Reference taken from pin one for the odd codes below 7
    always_ff @(posedge clk) begin
        if (!nrst)
            ref_from_pin_one <= 1'b0;
        else
            ref_from_pin_one <= port_config_code_q[0]
                                && port_config_code_q != 3'h7; // [RQ10]
    end

    // Trial code presented to the comparator
    always_ff @(posedge clk) begin
        if (!nrst)
            dac_code <= 8'h00;
        else
            dac_code <= sar_q;                              // [RQ1]
    end

    // Analog map as seen by the pins
    always_ff @(posedge clk) begin
        if (!nrst)
            pin_analog <= 4'hf;
        else
            pin_analog <= analog_map;                       // [RQ9]
    end

    // Analog pins read back as zero
    always_ff @(posedge clk) begin
        if (!nrst)
            port_pins_read <= 4'h0;
        else
            port_pins_read <= port_pins_in & ~analog_map;   // [RQ11]
    end

    // Done pulse, one cycle after the result loads
    always_ff @(posedge clk) begin
        if (!nrst)
            conversion_done_flag <= 1'b0;
        else
            conversion_done_flag <= done_q;                 // [RQ13]
    end

    // Pin-change side effect of a config write
    always_ff @(posedge clk) begin
        if (!nrst)
            pin_change_flag_set <= 1'b0;
        else
            pin_change_flag_set <= wr_cfg;                  // [RQ12]
    end

    // External-interrupt side effect of a config write
    always_ff @(posedge clk) begin
        if (!nrst)
            external_irq_flag_set <= 1'b0;
        else
            external_irq_flag_set <= wr_cfg;                // [RQ12]
    end

    // Bus answer: one wait cycle per access, then data and release
    assign rd_ok = avs_read && avs_waitrequest;

    // Read word for the addressed register; unmapped indices read zero
    always_comb begin
        case (avs_address[9:2])
            SAC_IDX_CTRL:   rd_word = {24'h00_0000, converter_control_q};
            SAC_IDX_PINCFG: rd_word = {29'h0000_0000, port_config_code_q};
            SAC_IDX_RESULT: rd_word = {24'h00_0000, conversion_result_q};
            SAC_IDX_STATUS: rd_word = {28'h000_0000, pin_analog};
            default:        rd_word = 32'h0000_0000;
        endcase
    end

    // Waitrequest drops for exactly one cycle per request
    always_ff @(posedge clk) begin
        if (!nrst)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end

    // Read data captured at the taking edge, stands at the answer edge
    always_ff @(posedge clk) begin
        if (!nrst)
            avs_readdata <= 32'h0000_0000;
        else if (rd_ok)
            avs_readdata <= rd_word;
    end

endmodule : sac_adc_ctrl

// File: sac_adc_ctrl_properties.sv
// Purpose: Port-level checks of the converter control block
// Assumes: Single clock, sync active-low reset
// Notes:   Attached by bind at the foot of this file
`timescale 1ns/1ps
module sac_adc_ctrl_properties (
    // Clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // Register bus
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic [9:0] avs_address,
    input wire logic       avs_waitrequest,
    // Converter state
    input wire logic       converter_powered,
    input wire logic       sample_switch_on,
    input wire logic       conversion_done_flag,
    input wire logic       pin_change_flag_set,
    input wire logic [3:0] pin_analog,
    input wire logic [3:0] port_pins_read
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_answer;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_wait_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("long ack");
    property p_done_pulse;
        conversion_done_flag |=> !conversion_done_flag;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done");
    property p_pin_flag;
        avs_write && avs_waitrequest && avs_address[9:2] == 8'h9f
            |-> ##[1:3] pin_change_flag_set;
    endproperty
    a_pin_flag: assert property (p_pin_flag) else $error("no flag");
    property p_hold_off;
        conversion_done_flag |-> !sample_switch_on [*2];
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("hold");
    property p_switch_power;
        sample_switch_on |-> converter_powered;
    endproperty
    a_switch_power: assert property (p_switch_power) else $error("pwr");
    property p_no_done_off;
        !converter_powered [*2] |=> !conversion_done_flag;
    endproperty
    a_no_done_off: assert property (p_no_done_off) else $error("off");
    property p_analog_zero;
        $stable(pin_analog) [*2] |-> (port_pins_read & pin_analog) == 4'h0;
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("pin");
    property p_reset;
        disable iff (1'b0) !nrst |=> avs_waitrequest && !converter_powered;
    endproperty
    a_reset: assert property (p_reset) else $error("reset");
    c_done: cover property (conversion_done_flag);
    c_flag: cover property (pin_change_flag_set);
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule : sac_adc_ctrl_properties

bind sac_adc_ctrl sac_adc_ctrl_properties u_sac_adc_ctrl_properties (
    .clk, .nrst, .avs_read, .avs_write, .avs_address, .avs_waitrequest,
    .converter_powered, .sample_switch_on, .conversion_done_flag,
    .pin_change_flag_set, .pin_analog, .port_pins_read);

// File: sac_front_model.sv
// Purpose: Analog front end: held sample, comparator, RC clock
// Assumes: Each input sits half a step above its code
// Notes:   RC ticks only while the converter is powered
`timescale 1ns/1ps
module sac_front_model #(
    parameter int RC_HALF = 8
) (
    // Clock
    input wire logic        clk,
    // Converter side
    input wire logic [1:0]  analog_mux_sel,
    input wire logic        sample_switch_on,
    input wire logic        converter_powered,
    input wire logic [7:0]  dac_code,
    output logic            comparator_high,
    output logic            rc_tick,
    // Input levels, channel 3 in the top byte
    input wire logic [31:0] levels
);
    logic [7:0] held_q;
    int         rc_cnt;
    initial begin
        held_q = 8'h00;
        rc_cnt = 0;
        rc_tick = 1'b0;
    end
    // Charge is kept between conversions, never discharged
    always @(posedge clk) begin
        if (sample_switch_on) held_q <= levels[analog_mux_sel*8 +: 8];
    end
    assign comparator_high = held_q >= dac_code;
    always @(posedge clk) begin
        rc_cnt  <= converter_powered ? (rc_cnt + 1) % RC_HALF : 0;
        rc_tick <= converter_powered && rc_cnt == RC_HALF - 1;
    end
endmodule : sac_front_model

// File: sac_adc_ctrl_bench.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Reads are checked by a monitor against a queue of notes
// Notes:   Random input levels and port pins from a fixed seed
`timescale 1ns/1ps
module sac_adc_ctrl_bench
    import sac_pkg::*;
();
    logic        clk, nrst, avs_read, avs_write, sleep_mode, rc_tick;
    logic [9:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, levels, expq[$];
    logic        avs_waitrequest, comparator_high, sample_switch_on;
    logic        converter_powered, ref_from_pin_one, conversion_done_flag;
    logic        pin_change_flag_set, external_irq_flag_set;
    logic [1:0]  analog_mux_sel;
    logic [7:0]  dac_code, last_res;
    logic [3:0]  port_pins_in, port_pins_read, pin_analog;
    int          miscompares, total_checks, seed, dones, d;
    localparam logic [3:0] AMAP [8] =
        '{4'hf, 4'hf, 4'h7, 4'h7, 4'h3, 4'h3, 4'h1, 4'h0};

    sac_adc_ctrl u_sac_adc_ctrl (.clk, .nrst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
        .avs_waitrequest, .rc_tick, .sleep_mode, .comparator_high,
        .analog_mux_sel, .sample_switch_on, .converter_powered,
        .ref_from_pin_one, .dac_code, .port_pins_in, .port_pins_read,
        .pin_analog, .conversion_done_flag, .pin_change_flag_set,
        .external_irq_flag_set);
    sac_front_model u_sac_front_model (.clk, .analog_mux_sel,
        .sample_switch_on, .converter_powered, .dac_code,
        .comparator_high, .rc_tick, .levels);

    initial clk = 1'b0;
    always #2 clk = ~clk;

    task automatic cmp(input string what, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : cmp

    task automatic summarize;
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] dat);
        int k;
        k = 0;
        avs_address   <= {idx, 2'b00};
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= dat;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) begin
            miscompares++;
            summarize;
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, idx, 32'h0);
    endtask : rd

    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0)
            cmp("readdata", expq.pop_front(), avs_readdata);
        if (conversion_done_flag === 1'b1) dones++;
    end

    task automatic convert(input logic [1:0] ck, ch);
        logic [31:0] lv;
        int c, h;
        lv = $random(seed);
        levels <= lv;
        h = ck == 2'd0 ? 1 : ck == 2'd1 ? 4 : 16;
        bus(1'b1, SAC_IDX_CTRL, {24'h0, ck, 1'b0, ch, 3'b001});
        repeat (80) @(posedge clk);
        bus(1'b1, SAC_IDX_CTRL, {24'h0, ck, 1'b0, ch, 3'b101});
        c = 0;
        while (conversion_done_flag !== 1'b1 && c < 4000) begin
            @(posedge clk);
            c++;
        end
        last_res = lv[ch*8 +: 8];
        if (ck != SAC_CLK_RC)
            cmp("conv_time", 1, c >= 19*h - 2 && c <= 20*h + 2);
        cmp("mux", ch, analog_mux_sel);
        rd(SAC_IDX_RESULT, {24'h0, last_res});
        rd(SAC_IDX_CTRL, {24'h0, ck, 1'b0, ch, 3'b001});
    endtask : convert

    initial begin
        seed = 32'h77b5;
        {miscompares, total_checks, dones} = '0;
        {nrst, avs_read, avs_write, sleep_mode} = '0;
        {avs_address, avs_writedata, levels, port_pins_in} = '0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(SAC_IDX_CTRL, 32'h0);
        rd(SAC_IDX_PINCFG, 32'h0);
        bus(1'b1, SAC_IDX_CTRL, 32'hffff_ffa2);
        rd(SAC_IDX_CTRL, 32'ha2);
        cmp("powered", 0, converter_powered);
        bus(1'b1, 8'hff, 32'h5a);
        rd(8'hff, 32'h0);
        bus(1'b1, SAC_IDX_PINCFG, 32'hffff_ffff);
        rd(SAC_IDX_PINCFG, 32'h7);
        for (int p = 0; p < 8; p++) begin
            bus(1'b1, SAC_IDX_PINCFG, 32'(p));
            port_pins_in <= 4'($random(seed));
            repeat (4) @(posedge clk);
            d = (p % 2 == 1 && p != 7) ? 4'hd : 4'hf;
            cmp("analog", AMAP[p] & d, pin_analog & d);
            cmp("ref", p % 2 == 1 && p != 7, ref_from_pin_one);
            cmp("port", port_pins_in & ~AMAP[p] & d,
                port_pins_read & d);
        end
        bus(1'b1, SAC_IDX_PINCFG, 32'h0);
        for (int k = 0; k < 4; k++) convert(2'(k), 2'(k));
        d = dones;
        bus(1'b1, SAC_IDX_CTRL, 32'h04);
        repeat (300) @(posedge clk);
        cmp("dones", d, dones);
        cmp("powered", 0, converter_powered);
        bus(1'b1, SAC_IDX_CTRL, 32'h81);
        repeat (80) @(posedge clk);
        bus(1'b1, SAC_IDX_CTRL, 32'h85);
        repeat (60) @(posedge clk);
        d = dones;
        bus(1'b1, SAC_IDX_CTRL, 32'h81);
        repeat (400) @(posedge clk);
        cmp("dones", d, dones);
        rd(SAC_IDX_RESULT, {24'h0, last_res});
        bus(1'b1, SAC_IDX_CTRL, 32'h45);
        repeat (20) @(posedge clk);
        sleep_mode <= 1'b1;
        repeat (150) @(posedge clk);
        cmp("dones", d, dones);
        rd(SAC_IDX_CTRL, 32'h41);
        sleep_mode <= 1'b0;
        bus(1'b1, SAC_IDX_CTRL, 32'h45);
        repeat (20) @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(SAC_IDX_CTRL, 32'h0);
        rd(SAC_IDX_RESULT, {24'h0, last_res});
        summarize;
    end
endmodule : sac_adc_ctrl_bench
